// ===== rtl/fbf_host.sv
// Host controller driving the flash bus operation pins.
`timescale 1ns/100ps
module fbf_host (
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    input wire logic req_valid_i,
    input wire fbf_pkg::fbf_req_t req_i,
    output logic req_ready_o,
    input wire logic clear_valid_i,
    output logic clear_ready_o,
    output logic rsp_valid_o,
    output logic [fbf_pkg::DATA_W-1:0] rsp_rdata_o,
    output logic busy_o,
    output logic restart_needed_o,
    output logic chip_sel_n_o,
    output logic out_gate_n_o,
    output logic wr_strobe_n_o,
    output logic hw_clear_n_o,
    output logic [fbf_pkg::ADDR_W-1:0] addr_lines_o,
    input wire logic [fbf_pkg::DATA_W-1:0] byte_lines_i,
    output logic [fbf_pkg::DATA_W-1:0] byte_lines_o,
    output logic byte_lines_oe_o,
    input wire logic op_done_flag_i
);
    import fbf_pkg::*;

    typedef struct packed {
        fbf_state_t st;
        logic [CNT_W-1:0] cnt;
        fbf_ctl_pins_t pins;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic dq_oe;
        logic [DATA_W-1:0] rdata;
        logic rsp;
        logic restart;
        logic [DATA_W-1:0] dq_s1;
        logic [DATA_W-1:0] dq_s2;
        logic done_s1;
        logic done_s2;
    } fbf_regs_t;

    localparam fbf_regs_t RST_REGS = '{
        st: FBF_IDLE,
        cnt: RST_CNT,
        pins: '{RST_PIN_HIGH, RST_PIN_HIGH, RST_PIN_HIGH, RST_PIN_HIGH},
        addr: '0,
        wdata: '0,
        dq_oe: 1'b0,
        rdata: '0,
        rsp: 1'b0,
        restart: 1'b0,
        dq_s1: '0,
        dq_s2: '0,
        done_s1: RST_PIN_HIGH,
        done_s2: RST_PIN_HIGH
    };

    fbf_regs_t r;
    fbf_regs_t next_r;
    logic idle;

    assign idle = (r.st == FBF_IDLE);
    assign clear_ready_o = idle;
    assign req_ready_o = idle && !clear_valid_i;

    always_comb begin
        next_r = r;
        next_r.rsp = 1'b0;
        // Pin inputs pass two flip-flops before any logic reads them.
        next_r.dq_s1 = byte_lines_i;
        next_r.dq_s2 = r.dq_s1;
        next_r.done_s1 = op_done_flag_i;
        next_r.done_s2 = r.done_s1;
        case (r.st)
            FBF_IDLE: begin
                if (clear_valid_i) begin
                    if (!r.done_s2) begin
                        next_r.restart = 1'b1;
                    end
                    next_r.pins.hw_clear_n = 1'b0;
                    next_r.cnt = CNT_W'(CLEAR_PULSE_MIN_CYC - 1);
                    next_r.st = FBF_CLR_PULSE;
                end else if (req_valid_i && req_i.wr) begin
                    next_r.restart = 1'b0;
                    next_r.addr = req_i.addr;
                    next_r.wdata = req_i.wdata;
                    next_r.pins.chip_sel_n = 1'b0;
                    next_r.pins.wr_strobe_n = 1'b0;
                    next_r.pins.out_gate_n = 1'b1;
                    next_r.dq_oe = 1'b1;
                    next_r.cnt = CNT_W'(WR_PULSE_CYC - 1);
                    next_r.st = FBF_WR_PULSE;
                end else if (req_valid_i) begin
                    next_r.addr = req_i.addr;
                    next_r.pins.chip_sel_n = 1'b0;
                    next_r.pins.out_gate_n = 1'b0;
                    next_r.pins.wr_strobe_n = 1'b1;
                    next_r.dq_oe = 1'b0;
                    next_r.cnt = CNT_W'(READ_WAIT_CYC - 1);
                    next_r.st = FBF_RD_WAIT;
                end
            end
            FBF_RD_WAIT: begin
                if (r.cnt == RST_CNT) begin
                    next_r.rdata = r.dq_s2;
                    next_r.rsp = 1'b1;
                    next_r.pins.chip_sel_n = 1'b1;
                    next_r.pins.out_gate_n = 1'b1;
                    next_r.st = FBF_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            FBF_WR_PULSE: begin
                if (r.cnt == RST_CNT) begin
                    next_r.pins.wr_strobe_n = 1'b1;
                    next_r.pins.chip_sel_n = 1'b1;
                    next_r.st = FBF_WR_HOLD;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            FBF_WR_HOLD: begin
                // Data is held one cycle past the strobe rising edge.
                next_r.dq_oe = 1'b0;
                next_r.rsp = 1'b1;
                next_r.st = FBF_IDLE;
            end
            FBF_CLR_PULSE: begin
                if (r.cnt == RST_CNT) begin
                    next_r.pins.hw_clear_n = 1'b1;
                    next_r.cnt = CNT_W'(CLEAR_TO_READ_DELAY_CYC - 1);
                    next_r.st = FBF_CLR_RECOVER;
                end else begin
                    next_r.cnt = r.cnt - 1'b1;
                end
            end
            FBF_CLR_RECOVER: begin
                if (r.cnt != RST_CNT) begin
                    next_r.cnt = r.cnt - 1'b1;
                end else if (r.done_s2) begin
                    next_r.rsp = 1'b1;
                    next_r.st = FBF_IDLE;
                end
            end
            default: begin
                next_r = RST_REGS;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= RST_REGS;
        end else begin
            r <= next_r;
        end
    end

    assign chip_sel_n_o = r.pins.chip_sel_n;
    assign out_gate_n_o = r.pins.out_gate_n;
    assign wr_strobe_n_o = r.pins.wr_strobe_n;
    assign hw_clear_n_o = r.pins.hw_clear_n;
    assign addr_lines_o = r.addr;
    assign byte_lines_o = r.wdata;
    assign byte_lines_oe_o = r.dq_oe;
    assign rsp_valid_o = r.rsp;
    assign rsp_rdata_o = r.rdata;
    assign busy_o = !r.done_s2;
    assign restart_needed_o = r.restart;

    AST_READ_LEVELS: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        !out_gate_n_o |-> !chip_sel_n_o && wr_strobe_n_o && hw_clear_n_o
            && !byte_lines_oe_o)
        else $error("Read cycle pin levels wrong.");

    AST_WRITE_LEVELS: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        !wr_strobe_n_o |-> !chip_sel_n_o && out_gate_n_o && byte_lines_oe_o)
        else $error("Write cycle pin levels wrong.");

    AST_NO_CONTENTION: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        byte_lines_oe_o |-> out_gate_n_o && hw_clear_n_o)
        else $error("Host drives data while gate is low.");

    AST_WRITE_WIDTH: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        $fell(wr_strobe_n_o) |-> !wr_strobe_n_o[*5] ##1 wr_strobe_n_o
            ##1 !byte_lines_oe_o && rsp_valid_o)
        else $error("Write strobe width wrong.");

    AST_READ_ACCESS: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        $fell(out_gate_n_o) |-> !out_gate_n_o[*8] ##1 !out_gate_n_o[*4]
            ##1 rsp_valid_o && out_gate_n_o)
        else $error("Read answer timing wrong.");

    AST_CLEAR_WIDTH: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        $fell(hw_clear_n_o) |-> !hw_clear_n_o[*8] ##1 hw_clear_n_o)
        else $error("Clear pulse width wrong.");

    AST_RESTART_FLAG: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        clear_valid_i && clear_ready_o && busy_o |=> restart_needed_o)
        else $error("Interrupted operation not flagged.");

    AST_RECOVERY: assert property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        $rose(hw_clear_n_o) |-> (out_gate_n_o && !req_ready_o)[*5])
        else $error("Read started inside clear recovery.");

    COV_READ: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $fell(out_gate_n_o) ##[1:20] rsp_valid_o);
    COV_WRITE: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        $fell(wr_strobe_n_o) ##[1:20] rsp_valid_o);
    COV_CLEAR_BUSY: cover property (@(posedge sys_clk_i)
        disable iff (!resetn_i)
        clear_valid_i && clear_ready_o && busy_o);

endmodule // fbf_host

// ===== rtl/fbf_pkg.sv
// Constants and types shared by the flash bus front end host controller.
package fbf_pkg;

    // Clock period of sys_clk_i in ns.
    localparam int CLK_PERIOD_NS = 10;

    // Pin timing figures in ns; plain defaults, tune for the fitted part.
    localparam int SELECT_ACCESS_NS = 100;
    localparam int WR_PULSE_NS = 50;
    localparam int CLEAR_PULSE_MIN_NS = 80;
    localparam int CLEAR_TO_READ_DELAY_NS = 50;

    // Cycle counts, least times rounded up to whole cycles.
    localparam int SELECT_ACCESS_CYC =
        (SELECT_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_PULSE_CYC =
        (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_PULSE_MIN_CYC =
        (CLEAR_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CLEAR_TO_READ_DELAY_CYC =
        (CLEAR_TO_READ_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Flip-flops between a pin and the logic that reads it.
    localparam int SYNC_STAGES = 2;
    localparam int READ_WAIT_CYC = SELECT_ACCESS_CYC + SYNC_STAGES;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 8;
    localparam int CNT_W = 8;

    // Values after reset.
    localparam logic RST_PIN_HIGH = 1'b1;
    localparam logic [CNT_W-1:0] RST_CNT = 8'h00;

    typedef enum logic [2:0] {
        FBF_IDLE,
        FBF_RD_WAIT,
        FBF_WR_PULSE,
        FBF_WR_HOLD,
        FBF_CLR_PULSE,
        FBF_CLR_RECOVER
    } fbf_state_t;

    // One request from the user side.
    typedef struct packed {
        logic wr;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fbf_req_t;

    // Control pins toward the flash.
    typedef struct packed {
        logic chip_sel_n;
        logic out_gate_n;
        logic wr_strobe_n;
        logic hw_clear_n;
    } fbf_ctl_pins_t;

endpackage

// ===== tb/fbf_flash_model.sv
// Behavioural model of the byte-wide flash seen from the host pins.
`timescale 1ns/100ps
module fbf_flash_model #(
    parameter int ACC_NS = 60,
    parameter int OP_NS = 2000,
    parameter int READY_NS = 300,
    // Arbitrary identification value.
    parameter logic [7:0] ID_CODE = 8'h5c,
    parameter logic [7:0] STATUS = 8'h0a
) (
    input wire logic cs_n_i,
    input wire logic oe_n_i,
    input wire logic we_n_i,
    input wire logic clr_n_i,
    input wire logic elevated_id_voltage_i,
    input wire logic [19:0] addr_i,
    input wire logic [7:0] data_i,
    output logic [7:0] byte_o,
    output logic drive_o,
    output logic op_done_o
);
    logic [7:0] mem [16];
    logic [7:0] last = 8'h00;
    logic [19:0] la = 20'h00555;
    logic [7:0] ld = 8'hf0;
    logic id_mode = 1'b0;
    logic op_done = 1'b1;
    time op_end = 0;
    logic wr_act, rd_en, rd_ok;
    initial for (int i = 0; i < 16; i++) mem[i] = 8'h30 + 8'(i);
    assign wr_act = !cs_n_i && !we_n_i && oe_n_i && clr_n_i;
    assign rd_en = !cs_n_i && !oe_n_i && we_n_i && clr_n_i;
    assign #(ACC_NS) rd_ok = rd_en;
    assign drive_o = rd_en && rd_ok;
    assign op_done_o = op_done;
    assign byte_o = drive_o ? last : ~last;
    always @* if (drive_o) begin
        last = !op_done ? STATUS : id_mode ? ID_CODE : mem[addr_i[3:0]];
    end
    always @* if (wr_act) begin
        la = addr_i;
        ld = data_i;
    end
    always @(negedge wr_act) begin
        // top sector locked unless elevated level
        if (la[11:0] != 12'h555) begin
            if (la[19:16] != 4'hf || elevated_id_voltage_i) mem[la[3:0]] = ld;
        end else if (ld == 8'h90) id_mode = 1'b1;
        else if (ld == 8'h10) begin
            op_done = 1'b0;
            op_end = $time + OP_NS;
        end else if (ld == 8'h30) begin
            // sector picked by top address bits
            if (la[19:16] == 4'h0) begin
                for (int i = 0; i < 16; i++) mem[i] = 8'hff;
            end
            op_done = 1'b0;
            op_end = $time + OP_NS;
        end else id_mode = 1'b0;
    end
    always #5 if (!op_done && $time >= op_end) op_done = 1'b1;
    always @(negedge clr_n_i) begin
        id_mode = 1'b0;
        if (!op_done) op_end = $time + READY_NS;
    end
endmodule // fbf_flash_model

// ===== tb/tb_fbf_host.sv
// Self-checking bench for the flash host controller.
`timescale 1ns/100ps
module tb_fbf_host;
    import fbf_pkg::*;
    localparam logic [7:0] ID = 8'h5c;
    localparam logic [7:0] ST = 8'h0a;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic req_valid = 1'b0;
    logic clear_valid = 1'b0;
    logic elevated_id_voltage = 1'b0;
    fbf_req_t req = '0;
    logic req_ready, clear_ready, rsp_valid, busy, restart;
    logic cs_n, oe_n, we_n, clr_n, host_oe, dev_drive, op_done;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] rdata, host_d, dev_byte, pin;
    int n_errors = 0;
    int checks_done = 0;
    always #5 clk = ~clk;
    assign pin = host_oe ? host_d : dev_byte;
    fbf_host DUT (.sys_clk_i(clk), .resetn_i(resetn),
        .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
        .clear_valid_i(clear_valid), .clear_ready_o(clear_ready),
        .rsp_valid_o(rsp_valid), .rsp_rdata_o(rdata), .busy_o(busy),
        .restart_needed_o(restart), .chip_sel_n_o(cs_n),
        .out_gate_n_o(oe_n), .wr_strobe_n_o(we_n), .hw_clear_n_o(clr_n),
        .addr_lines_o(addr), .byte_lines_i(pin), .byte_lines_o(host_d),
        .byte_lines_oe_o(host_oe), .op_done_flag_i(op_done));
    fbf_flash_model #(.ID_CODE(ID), .STATUS(ST)) flash (.cs_n_i(cs_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .clr_n_i(clr_n), .addr_i(addr),
        .elevated_id_voltage_i(elevated_id_voltage),
        .data_i(host_d), .byte_o(dev_byte), .drive_o(dev_drive),
        .op_done_o(op_done));
    task automatic results();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wait_rsp(input int lim);
        for (int i = 0; i < lim && rsp_valid !== 1'b1; i++) @(negedge clk);
        if (rsp_valid !== 1'b1) begin
            n_errors++;
            results();
        end
    endtask
    task automatic wait_ready(input int lim);
        repeat (2) @(negedge clk);
        for (int i = 0; i < lim && busy !== 1'b0; i++) @(negedge clk);
        if (busy !== 1'b0) begin
            n_errors++;
            results();
        end
    endtask
    task automatic op(input logic w, input logic [19:0] a,
        input logic [7:0] d);
        req = '{w, a, d};
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        wait_rsp(40);
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        op(1'b0, a, 8'h00);
        check("rdata", rdata, e);
    endtask
    task automatic clear(input int lim);
        clear_valid = 1'b1;
        @(negedge clk);
        clear_valid = 1'b0;
        repeat (2) @(negedge clk);
        check("clr", {7'h0, clr_n}, 8'h00);
        check("drive", {7'h0, dev_drive}, 8'h00);
        wait_rsp(lim);
    endtask
    // no fight on the byte lines
    always @(negedge clk) if (host_oe === 1'b1) begin
        check("fight", {7'h0, dev_drive}, 8'h00);
    end
    task automatic sc_reset();
        check("sel", {7'h0, cs_n}, 8'h01);
        check("drive", {7'h0, dev_drive}, 8'h00);
        rd(20'h00003, 8'h33);
    endtask
    task automatic sc_prog();
        op(1'b1, 20'h00005, 8'ha7);
        rd(20'h00005, 8'ha7);
        op(1'b1, 20'h00555, 8'hf0);
        rd(20'h10555, 8'ha7);
        op(1'b1, 20'h00555, 8'h90);
        rd(20'h00007, ID);
        op(1'b1, 20'h00555, 8'hf0);
        rd(20'h00007, 8'h37);
    endtask
    task automatic sc_busy();
        op(1'b1, 20'h00555, 8'h10);
        rd(20'h00002, ST);
        check("busy", {7'h0, busy}, 8'h01);
        wait_ready(400);
        check("busy", {7'h0, busy}, 8'h00);
        rd(20'h00002, 8'h32);
    endtask
    task automatic sc_clear();
        op(1'b1, 20'h00555, 8'h10);
        repeat (3) @(negedge clk);
        clear(60);
        check("restart", {7'h0, restart}, 8'h01);
        check("busy", {7'h0, busy}, 8'h00);
        rd(20'h00002, 8'h32);
        op(1'b1, 20'h00006, 8'h5e);
        check("restart", {7'h0, restart}, 8'h00);
        op(1'b1, 20'h00555, 8'h90);
        clear(20);
        check("restart", {7'h0, restart}, 8'h00);
        rd(20'h00007, 8'h37);
        rd(20'h00007, 8'h37);
        rd(20'h00006, 8'h5e);
    endtask
    task automatic sc_sector();
        op(1'b1, 20'hf000e, 8'h11);
        rd(20'hf000e, 8'h3e);
        elevated_id_voltage = 1'b1;
        op(1'b1, 20'hf000e, 8'h11);
        elevated_id_voltage = 1'b0;
        rd(20'hf000e, 8'h11);
        op(1'b1, 20'h10555, 8'h30);
        wait_ready(400);
        rd(20'h00003, 8'h33);
        op(1'b1, 20'h00555, 8'h30);
        wait_ready(400);
        rd(20'h00003, 8'hff);
    endtask
    initial begin
        repeat (5) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        sc_reset();
        sc_prog();
        sc_busy();
        sc_clear();
        sc_sector();
        results();
    end
endmodule // tb_fbf_host
